// ==== hw/tape_status_error_handling.sv ====
`timescale 1ns/1ns
// Function
// - Pointer write clears status error bits except fatal, class and special-condition.
// - Special-condition cleared on pointer write only if raised by refusal or memory error.
// - Extended error bits cleared only after end message reaches host memory.
// - Every command clears extended errors; keeps transport code and limit-exceeded.
// - Density check during read, space, skip sets flag; operation continues.
// - Density check alone at finish reports normal termination.
// - Wrong-density tape reports further errors and stops the operation.
// - Density flag holds until beginning-of-tape or subsystem initialize.
// - Write with density flag still set ends with class 6.
// - New command while one runs is refused, except listed cases.
// - Status word write is initialize: halts operation, erases stored parameters.
// - After initialize with on-line switch on, auto-load to beginning-of-tape.
// - Rewind-unload off-line keeps ready high, accepts non-motion commands.
// - Off-line, non-maintenance: accept status, drive init, characteristics, release.
// - Maintenance off-line: ready low, every command refused.
// - Early memory or parity fault before enable fetch may raise no interrupt.
// - After early fetch fault ready may stay low until initialize.
// - Skip tape marks runs in hardware here.
// - Space records past end-of-tape ends only on drive done, tape mark or wrong density.
// - Skip tape marks likewise ignores end-of-tape.
// - Running skip aborted only by initialize, which also auto-loads when the on-line switch is on.
// - Class 6 means unrecoverable, position lost.
// - Class 0 means normal termination.
// - Each command started from idle, not hung by an early fetch fault and not halted by initialize, ends with an end message holding the extended words.
module tape_status_error_handling
  import tape_status_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire bus_req_type bus_i,
  output logic [15:0] rdata_o,
  input wire drive_event_type drive_i,
  input wire logic online_switch_i,
  input wire logic maintenance_i,
  input wire logic rewind_unload_i,
  input wire logic msg_written_i,
  output logic [3:0] motion_cmd_o,
  output logic motion_start_o,
  output logic motion_halt_o,
  output logic [COUNT_WIDTH-1:0] record_count_o,
  output logic auto_load_o,
  output logic msg_send_o,
  output logic interrupt_o
);

  initial
  begin
    if (COUNT_WIDTH < 1 || COUNT_WIDTH > 16)
      $error("COUNT_WIDTH must lie in 1..16");
  end

  typedef enum logic [1:0] {IDLE, RUN, SEND, HUNG} phase_type;

  // ***************************************************
  // Decode
  // ***************************************************
  logic status_write;
  logic pointer_write;
  logic [3:0] cmd_code;
  logic is_motion;
  logic is_offline_ok;
  logic accept;
  logic [15:0] status_word;
  phase_type phase;
  logic busy;
  logic ready;

  assign status_write = bus_i.wr && bus_i.addr == STATUS_OFFSET;
  assign pointer_write = bus_i.wr && bus_i.addr == POINTER_OFFSET;
  assign cmd_code = bus_i.wdata[3:0];
  assign is_motion = cmd_code == CMD_READ || cmd_code == CMD_WRITE
                     || cmd_code == CMD_SPACE || cmd_code == CMD_SKIP;
  assign is_offline_ok = cmd_code == CMD_GET_STATUS || cmd_code == CMD_DRIVE_INIT
                         || cmd_code == CMD_SET_CHAR || cmd_code == CMD_MSG_RELEASE;
  assign busy = phase != IDLE;

  // Ready drops only in maintenance off-line or after an early fetch fault
  assign ready = !(maintenance_i && !online_switch_i) && phase != HUNG;

  always_comb
  begin
    accept = 1'b0;
    if (pointer_write && ready)
    begin
      if (!busy)
        accept = online_switch_i || is_offline_ok;
      else if (rewind_unload_i && !is_motion)
        accept = 1'b1;
    end
  end

  // ***************************************************
  // Status register bits
  // ***************************************************
  logic refused;
  logic absent_mem;
  logic parity;
  logic special;
  logic special_from_status;
  logic [2:0] term_class;
  logic refuse_now;

  assign refuse_now = pointer_write && !accept;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || status_write)
    begin
      refused <= 1'b0;
      absent_mem <= 1'b0;
      parity <= 1'b0;
    end
    else
    begin
      // Set wins over clear in the same cycle
      if (refuse_now)
        refused <= 1'b1;
      else if (pointer_write)
        refused <= 1'b0;
      if (drive_i.absent_memory && busy)
        absent_mem <= 1'b1;
      else if (pointer_write)
        absent_mem <= 1'b0;
      if (drive_i.parity_fault && busy)
        parity <= 1'b1;
      else if (pointer_write)
        parity <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || status_write)
    begin
      special <= 1'b0;
      special_from_status <= 1'b0;
    end
    else if (refuse_now || (busy && drive_i.absent_memory))
    begin
      special <= 1'b1;
      special_from_status <= 1'b1;
    end
    else if (phase == SEND && msg_written_i && term_class != TC_NORMAL)
    begin
      special <= 1'b1;
      special_from_status <= 1'b0;
    end
    else if (pointer_write && special_from_status)
      special <= 1'b0;
  end

  // ***************************************************
  // Command sequencing
  // ***************************************************
  logic [3:0] active_cmd;
  logic [COUNT_WIDTH-1:0] count_left;
  logic density_flag;
  logic eot_seen;
  logic limit_exceeded;
  logic wrong_density_seen;
  logic [15:0] xs3_transport;
  logic ie_fetched;
  logic finish;
  logic [2:0] next_class;

  // Drive done, wrong density or tape mark ends space and skip; end-of-tape never does
  assign finish = phase == RUN && (drive_i.done || drive_i.wrong_density
                  || ((active_cmd == CMD_SPACE || active_cmd == CMD_SKIP)
                      && drive_i.tape_mark));

  always_comb
  begin
    next_class = TC_NORMAL;
    if (drive_i.wrong_density)
      next_class = TC_POS_LOST;
    else if (drive_i.tape_mark)
      next_class = TC_ALERT;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || status_write)
    begin
      phase <= IDLE;
      active_cmd <= CMD_GET_STATUS;
      term_class <= TC_NORMAL;
      ie_fetched <= 1'b0;
    end
    else
    begin
      case (phase)
        IDLE:
        begin
          if (accept)
          begin
            active_cmd <= cmd_code;
            ie_fetched <= 1'b0;
            if (cmd_code == CMD_WRITE && density_flag)
            begin
              term_class <= TC_POS_LOST;
              phase <= SEND;
            end
            else if (is_motion)
              phase <= RUN;
            else
            begin
              term_class <= TC_NORMAL;
              phase <= SEND;
            end
          end
        end
        RUN:
        begin
          if (drive_i.ie_fetched)
            ie_fetched <= 1'b1;
          if ((drive_i.absent_memory || drive_i.parity_fault) && !ie_fetched)
            phase <= HUNG;
          else if (finish)
          begin
            term_class <= next_class;
            phase <= SEND;
          end
        end
        SEND:
        begin
          if (msg_written_i)
            phase <= IDLE;
        end
        HUNG:
          phase <= HUNG;
        default:
          phase <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_left <= '0;
    else if (accept && !busy)
      count_left <= bus_i.wdata[15:16-COUNT_WIDTH];
    else if (phase == RUN && drive_i.done && count_left != '0)
      count_left <= count_left - 1'b1;
  end

  // ***************************************************
  // Extended status
  // ***************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i || status_write)
    begin
      density_flag <= 1'b0;
      eot_seen <= 1'b0;
      wrong_density_seen <= 1'b0;
      limit_exceeded <= 1'b0;
      xs3_transport <= RESET_WORD;
    end
    else
    begin
      if (phase == RUN && drive_i.density_check && active_cmd != CMD_WRITE)
        density_flag <= 1'b1;
      else if (drive_i.at_bot)
        density_flag <= 1'b0;
      if (drive_i.at_eot)
        eot_seen <= 1'b1;
      else if (drive_i.at_bot)
        eot_seen <= 1'b0;
      if (phase == RUN && drive_i.wrong_density)
        wrong_density_seen <= 1'b1;
      else if (phase == SEND && msg_written_i)
        wrong_density_seen <= 1'b0;
      if (phase == RUN && drive_i.done && count_left == '0)
        limit_exceeded <= 1'b1;
      if (phase == RUN && drive_i.wrong_density)
        xs3_transport <= XS3_KEEP_MASK & {8'h01, 8'h00};
    end
  end

  logic [15:0] xs0_word;
  logic [15:0] xs3_word;
  assign xs0_word = 16'h0000 | ({15'h0000, eot_seen} << EOT_POS)
                    | ({15'h0000, wrong_density_seen} << 0);
  assign xs3_word = (xs3_transport & XS3_KEEP_MASK)
                    | ({15'h0000, limit_exceeded} << LXS_POS)
                    | ({15'h0000, density_flag} << DCK_POS);

  assign status_word = ({15'h0000, special} << SC_BIT)
                       | ({15'h0000, absent_mem} << NXM_POS)
                       | ({15'h0000, refused} << RMR_POS)
                       | ({15'h0000, ready} << SSR_POS)
                       | ({15'h0000, parity} << BPE_POS)
                       | ({13'h0000, term_class} << TC_LSB);

  // ***************************************************
  // Bus read and drive outputs
  // ***************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= RESET_WORD;
    else if (bus_i.rd)
    begin
      case (bus_i.addr)
        STATUS_OFFSET: rdata_o <= status_word;
        XSTAT0_OFFSET: rdata_o <= xs0_word;
        THIRD_EXTENDED_STATUS_WORD_OFFSET: rdata_o <= xs3_word;
        default: rdata_o <= RESET_WORD;
      endcase
    end
    else
      rdata_o <= RESET_WORD;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      motion_cmd_o <= CMD_GET_STATUS;
      motion_start_o <= 1'b0;
      motion_halt_o <= 1'b0;
      auto_load_o <= 1'b0;
      msg_send_o <= 1'b0;
      interrupt_o <= 1'b0;
      record_count_o <= '0;
    end
    else
    begin
      motion_start_o <= accept && !busy && is_motion
                        && !(cmd_code == CMD_WRITE && density_flag);
      motion_cmd_o <= accept && !busy ? cmd_code : motion_cmd_o;
      record_count_o <= count_left;
      motion_halt_o <= status_write;
      auto_load_o <= status_write && online_switch_i;
      msg_send_o <= phase == SEND && !msg_written_i;
      interrupt_o <= phase == SEND && msg_written_i;
    end
  end

endmodule

// ==== hw/tape_status_pkg.sv ====
package tape_status_pkg;

  // ***************************************************
  // Register offsets (word index on the plain port)
  // ***************************************************
  localparam logic [3:0] STATUS_OFFSET = 4'h0;
  localparam logic [3:0] POINTER_OFFSET = 4'h1;
  localparam logic [3:0] XSTAT0_OFFSET = 4'h2;
  localparam logic [3:0] XSTAT1_OFFSET = 4'h3;
  localparam logic [3:0] XSTAT2_OFFSET = 4'h4;
  localparam logic [3:0] THIRD_EXTENDED_STATUS_WORD_OFFSET = 4'h5;
  localparam logic [3:0] XSTAT4_OFFSET = 4'h6;

  // ***************************************************
  // Status register field positions
  // ***************************************************
  localparam int SC_BIT = 15;
  localparam int RMR_POS = 9;
  localparam int NXM_POS = 11;
  localparam int SSR_POS = 7;
  localparam int TC_LSB = 1;
  localparam int BPE_POS = 5;

  // ***************************************************
  // Extended status field positions
  // ***************************************************
  localparam int XS3_KEEP_LSB = 8;
  localparam int LXS_POS = 14;
  localparam int DCK_POS = 10;
  localparam int EOT_POS = 9;
  localparam logic [15:0] XS3_KEEP_MASK = 16'hff00;

  // ***************************************************
  // Termination classes and commands
  // ***************************************************
  localparam logic [2:0] TC_NORMAL = 3'h0;
  localparam logic [2:0] TC_ALERT = 3'h2;
  localparam logic [2:0] TC_REJECT = 3'h3;
  localparam logic [2:0] TC_POS_LOST = 3'h6;

  localparam logic [3:0] CMD_GET_STATUS = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h1;
  localparam logic [3:0] CMD_SET_CHAR = 4'h4;
  localparam logic [3:0] CMD_WRITE = 4'h5;
  localparam logic [3:0] CMD_SPACE = 4'h8;
  localparam logic [3:0] CMD_SKIP = 4'h9;
  localparam logic [3:0] CMD_MSG_RELEASE = 4'hb;
  localparam logic [3:0] CMD_DRIVE_INIT = 4'hc;

  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic done;
    logic tape_mark;
    logic at_bot;
    logic at_eot;
    logic density_check;
    logic wrong_density;
    logic absent_memory;
    logic parity_fault;
    logic ie_fetched;
  } drive_event_type;

endpackage

// ==== testbench/tape_status_props.sv ====
`timescale 1ns/1ns
module tape_status_props
  import tape_status_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire bus_req_type bus_i,
  input wire logic [15:0] rdata_o,
  input wire drive_event_type drive_i,
  input wire logic online_switch_i,
  input wire logic maintenance_i,
  input wire logic rewind_unload_i,
  input wire logic msg_written_i,
  input wire logic [3:0] motion_cmd_o,
  input wire logic motion_start_o,
  input wire logic motion_halt_o,
  input wire logic [COUNT_WIDTH-1:0] record_count_o,
  input wire logic auto_load_o,
  input wire logic msg_send_o,
  input wire logic interrupt_o
);
  logic init_wr;
  logic cmd_wr;
  logic [3:0] wcode;
  assign init_wr = bus_i.wr && bus_i.addr == STATUS_OFFSET;
  assign cmd_wr = bus_i.wr && bus_i.addr == POINTER_OFFSET;
  assign wcode = bus_i.wdata[3:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // Port relations
  // ****
  init_halt_a: assert property (init_wr |=> motion_halt_o)
    else $error("initialize without halt");
  auto_load_a: assert property (init_wr && online_switch_i |=> auto_load_o)
    else $error("initialize without auto load");
  busy_refuse_a: assert property (cmd_wr && msg_send_o |=> !motion_start_o)
    else $error("command taken while busy");
  start_cause_a: assert property (motion_start_o |-> $past(cmd_wr) && motion_cmd_o == $past(wcode))
    else $error("motion start without its command");
  maint_refuse_a: assert property (cmd_wr && maintenance_i && !online_switch_i |=> !motion_start_o)
    else $error("maintenance command taken");
  maint_ready_a: assert property (bus_i.rd && bus_i.addr == STATUS_OFFSET && maintenance_i
    && !online_switch_i |=> !rdata_o[SSR_POS])
    else $error("ready shown in maintenance");
  offline_read_a: assert property (cmd_wr && !online_switch_i && wcode == CMD_READ
    |=> !motion_start_o)
    else $error("motion started off line");
  msg_hold_a: assert property (msg_send_o && !msg_written_i && !init_wr |=> msg_send_o)
    else $error("end message request dropped");
  int_cause_a: assert property (interrupt_o |-> $past(msg_written_i) && $past(msg_send_o))
    else $error("interrupt without delivered message");
endmodule
bind tape_status_error_handling tape_status_props #(.COUNT_WIDTH(COUNT_WIDTH)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .drive_i(drive_i),
  .online_switch_i(online_switch_i), .maintenance_i(maintenance_i),
  .rewind_unload_i(rewind_unload_i), .msg_written_i(msg_written_i),
  .motion_cmd_o(motion_cmd_o), .motion_start_o(motion_start_o), .motion_halt_o(motion_halt_o),
  .record_count_o(record_count_o), .auto_load_o(auto_load_o), .msg_send_o(msg_send_o),
  .interrupt_o(interrupt_o));

// ==== testbench/tape_host_model.sv ====
`timescale 1ns/1ns
module tape_host_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic msg_send_i,
  input wire logic slow_i,
  output logic msg_written_o
);
  logic [3:0] wait_count;
  logic served;
  // ****
  // End message stored in host memory
  // ****
  always_ff @(posedge clk_i)
  begin
    msg_written_o <= 1'b0;
    if (rst_i || !msg_send_i)
    begin
      wait_count <= 4'h0;
      served <= 1'b0;
    end
    else if (!served)
    begin
      wait_count <= wait_count + 4'h1;
      if (wait_count == (slow_i ? 4'h7 : 4'h0))
      begin
        // Buffer address taken as set up before the first message
        msg_written_o <= 1'b1;
        served <= 1'b1;
      end
    end
  end
endmodule

// ==== testbench/tape_status_error_handling_test.sv ====
`timescale 1ns/1ns
module tape_status_error_handling_test;
  import tape_status_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  bus_req_type bus = '0;
  logic [8:0] drv = 9'h000;
  logic online = 1;
  logic maint = 0;
  logic rwu = 0;
  logic slow = 0;
  logic written;
  logic [15:0] rdata_o;
  logic msg_send_o;
  logic interrupt_o;
  logic [3:0] eot_cmds [2] = '{CMD_SPACE, CMD_SKIP};
  logic [3:0] off_cmds [4] = '{CMD_GET_STATUS, CMD_DRIVE_INIT, CMD_SET_CHAR, CMD_MSG_RELEASE};
  int fail_count = 0;
  int samples_checked = 0;
  int ints = 0;
  int n = 0;
  // ****
  // Clock, host and device
  // ****
  initial forever #5 clk_i = ~clk_i;
  tape_host_model u_host (.clk_i(clk_i), .rst_i(rst_i), .msg_send_i(msg_send_o),
    .slow_i(slow), .msg_written_o(written));
  tape_status_error_handling u_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus),
    .rdata_o(rdata_o), .drive_i(drive_event_type'(drv)), .online_switch_i(online),
    .maintenance_i(maint), .rewind_unload_i(rwu), .msg_written_i(written), .motion_cmd_o(),
    .motion_start_o(), .motion_halt_o(), .record_count_o(), .auto_load_o(),
    .msg_send_o(msg_send_o), .interrupt_o(interrupt_o));
  always @(posedge clk_i) if (interrupt_o === 1'b1) ints++;
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] c);
    n = ints;
    wr(POINTER_OFFSET, {12'h001, c});
  endtask
  task automatic reg_is(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_i);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1;
    chk($sformatf("reg %0d", a), e, rdata_o & m);
  endtask
  task automatic pulse(input logic [8:0] m);
    @(posedge clk_i);
    drv <= drv | m;
    @(posedge clk_i);
    drv <= drv & ~m;
  endtask
  task automatic wait_int();
    repeat (60) if (ints == n) @(posedge clk_i);
    chk("interrupt", 16'h0001, 16'(ints != n));
  endtask
  initial
  begin
    #200_000;
    fail_count++;
    final_report();
  end
  // ****
  // Scenarios
  // ****
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    cmd(CMD_READ);
    pulse(9'h010);
    repeat (4) @(posedge clk_i);
    chk("busy", 16'h0000, {15'h0000, msg_send_o});
    pulse(9'h100);
    wait_int();
    reg_is(STATUS_OFFSET, 16'h000e, 16'h0000);
    reg_is(THIRD_EXTENDED_STATUS_WORD_OFFSET, 16'h0400, 16'h0400);
    cmd(CMD_WRITE);
    pulse(9'h100);
    wait_int();
    reg_is(STATUS_OFFSET, 16'h000e, 16'h000c);
    reg_is(THIRD_EXTENDED_STATUS_WORD_OFFSET, 16'h0400, 16'h0400);
    pulse(9'h040);
    reg_is(THIRD_EXTENDED_STATUS_WORD_OFFSET, 16'h0400, 16'h0000);
    slow <= 1'b1;
    cmd(CMD_SPACE);
    wr(POINTER_OFFSET, {12'h001, CMD_READ});
    reg_is(STATUS_OFFSET, 16'h8200, 16'h8200);
    pulse(9'h080);
    wait_int();
    cmd(CMD_GET_STATUS);
    wait_int();
    // Alert ending raised special-condition again, so the pointer write keeps it
    reg_is(STATUS_OFFSET, 16'h8200, 16'h8000);
    slow <= 1'b0;
    drv[5] <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      cmd(eot_cmds[i]);
      repeat (10) @(posedge clk_i);
      chk("busy", 16'h0000, {15'h0000, msg_send_o});
      pulse(9'h080);
      wait_int();
      reg_is(STATUS_OFFSET, 16'h000e, 16'h0004);
    end
    drv[5] <= 1'b0;
    cmd(CMD_READ);
    pulse(9'h008);
    wait_int();
    reg_is(STATUS_OFFSET, 16'h000e, 16'h000c);
    online <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      cmd(off_cmds[i]);
      wait_int();
      reg_is(STATUS_OFFSET, 16'h0200, 16'h0000);
    end
    cmd(CMD_READ);
    reg_is(STATUS_OFFSET, 16'h0200, 16'h0200);
    rwu <= 1'b1;
    reg_is(STATUS_OFFSET, 16'h0080, 16'h0080);
    cmd(CMD_GET_STATUS);
    wait_int();
    reg_is(STATUS_OFFSET, 16'h0200, 16'h0000);
    rwu <= 1'b0;
    maint <= 1'b1;
    reg_is(STATUS_OFFSET, 16'h0080, 16'h0000);
    cmd(CMD_GET_STATUS);
    reg_is(STATUS_OFFSET, 16'h8200, 16'h8200);
    maint <= 1'b0;
    // Refusal raised special-condition, so an accepted pointer write drops it
    cmd(CMD_GET_STATUS);
    wait_int();
    reg_is(STATUS_OFFSET, 16'h8200, 16'h0000);
    online <= 1'b1;
    wr(STATUS_OFFSET, RESET_WORD);
    cmd(CMD_READ);
    pulse(9'h004);
    repeat (20) @(posedge clk_i);
    chk("interrupts", n[15:0], ints[15:0]);
    reg_is(STATUS_OFFSET, 16'h0880, 16'h0800);
    wr(STATUS_OFFSET, RESET_WORD);
    reg_is(STATUS_OFFSET, 16'h0080, 16'h0080);
    cmd(CMD_SKIP);
    repeat (5) @(posedge clk_i);
    wr(STATUS_OFFSET, RESET_WORD);
    cmd(CMD_GET_STATUS);
    wait_int();
    reg_is(STATUS_OFFSET, 16'h0200, 16'h0000);
    final_report();
  end
endmodule
